// *** sac_conversion_control.sv ***
// Purpose: Conversion control around a 10-bit successive-approximation core.
// Assumes: APB slave, zero wait states; analog core answers one decision per step.
// Notes:   Read side effects act in the APB setup cycle, when read data is captured.
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
// What this block does
// - Mux enable with converter off routes channel pins 0-7 to comparator minus.
// - Pin input disable bits force the matching port input bit to zero.
// - Result is 10 bits, zero is ground, all ones is reference less one step.
// - Reference and channel reach the converter only while it is enabled.
// - Ground and bandgap are selectable inputs besides the pins.
// - Result is right justified, or left justified when left adjust is set.
// - Reading the low byte blocks result updates; a blocked result is lost.
// - Reading the high byte unblocks result updates.
// - Completion flag sets even when the result was lost.
// - Writing start begins one conversion, or free running; start clears on completion unless free running.
// - A channel change during a conversion applies after it completes.
// - A trigger rising edge restarts the prescaler and starts a conversion.
// - A trigger still high at completion does not start another conversion.
// - Trigger edges during a conversion are ignored.
// - A trigger source flag sets regardless of interrupt masking.
// - Completion flag as trigger gives free running regardless of the flag.
// - With auto trigger on, writing start still begins a conversion.
// - Start reads one during every conversion, however started.
// - A conversion takes 13 steps, the first after enabling 25.
// - Completion writes data unless blocked and sets the flag; single mode clears start.
// - The prescaler runs only while enabled and is held reset otherwise.
module sac_conversion_control (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  trigger_sources,
  input  wire logic        core_decision,
  output logic             core_enable,
  output logic      [3:0]  core_channel,
  output logic      [1:0]  core_reference,
  output logic             core_sample,
  output logic      [9:0]  dac_code,
  input  wire logic [1:0]  comparator_pin_raw,
  output logic      [1:0]  port_input_bits,
  output logic             comparator_neg_from_mux,
  output logic      [2:0]  comparator_neg_channel,
  output logic             conversion_irq
);

  sac_pkg::sac_state_e state_r;
  sac_pkg::sac_state_e state_nxt;

  logic [7:0]  chref_r;
  logic        enable_r;
  logic        auto_r;
  logic        ie_r;
  logic [2:0]  prescale_r;
  logic        cmp_mux_en_r;
  logic [2:0]  trig_sel_r;
  logic [1:0]  pin_dis_r;
  logic        power_red_r;
  logic        flag_r;
  logic        lock_r;
  logic        first_r;
  logic [9:0]  data_r;
  logic [9:0]  sar_r;
  logic [3:0]  bit_r;
  logic [4:0]  step_r;
  logic [3:0]  applied_ch_r;
  logic [1:0]  applied_ref_r;
  logic [7:0]  trig_s1_r;
  logic [7:0]  trig_s2_r;
  logic        trig_prev_r;
  logic        dec_s1_r;
  logic        dec_s2_r;
  logic [1:0]  pin_s1_r;
  logic [1:0]  pin_s2_r;
  logic [1:0]  port_in_r;
  logic        sample_r;
  logic        neg_mux_r;
  logic [2:0]  neg_ch_r;
  logic [31:0] prdata_r;

  logic        wr_acc;
  logic        rd_setup;
  logic        addr_hit;
  logic        wr_chref;
  logic        wr_ctrl_a;
  logic        wr_ctrl_b;
  logic        wr_pin_dis;
  logic        wr_power;
  logic        rd_lo;
  logic        rd_hi;
  logic        eff_en;
  logic        conv_tick;
  logic        wr_start;
  logic        freerun;
  logic        trig_now;
  logic        trig_edge;
  logic        trig_fire;
  logic        presc_restart;
  logic        done;
  logic        on_sample;
  logic        on_decide;
  logic [4:0]  total;
  logic [4:0]  last_step;
  logic [4:0]  sample_step;
  logic [9:0]  bit_hot;
  logic [9:0]  sar_kept;
  logic [9:0]  sar_nxt;
  logic [7:0]  res_hi;
  logic [7:0]  res_lo;
  logic [7:0]  ctrl_a_rd;
  logic [7:0]  rd_byte;
  logic        update_sel;

  // APB decode; the slave never inserts wait states.
  assign pready     = 1'b1;
  assign wr_acc     = psel && penable && pwrite;
  assign rd_setup   = psel && !penable && !pwrite;
  assign addr_hit   = (paddr == sac_pkg::ADDR_CHREF) || (paddr == sac_pkg::ADDR_CTRL_A) ||
                      (paddr == sac_pkg::ADDR_CTRL_B) || (paddr == sac_pkg::ADDR_RES_LO) ||
                      (paddr == sac_pkg::ADDR_RES_HI) || (paddr == sac_pkg::ADDR_PIN_DIS) ||
                      (paddr == sac_pkg::ADDR_POWER);
  assign pslverr    = psel && penable && !addr_hit;
  assign wr_chref   = wr_acc && (paddr == sac_pkg::ADDR_CHREF);
  assign wr_ctrl_a  = wr_acc && (paddr == sac_pkg::ADDR_CTRL_A);
  assign wr_ctrl_b  = wr_acc && (paddr == sac_pkg::ADDR_CTRL_B);
  assign wr_pin_dis = wr_acc && (paddr == sac_pkg::ADDR_PIN_DIS);
  assign wr_power   = wr_acc && (paddr == sac_pkg::ADDR_POWER);
  assign rd_lo      = rd_setup && (paddr == sac_pkg::ADDR_RES_LO);
  assign rd_hi      = rd_setup && (paddr == sac_pkg::ADDR_RES_HI);

  assign eff_en   = enable_r && !power_red_r;
  assign wr_start = wr_ctrl_a && pwdata[sac_pkg::CA_START] && pwdata[sac_pkg::CA_ENABLE];
  assign freerun  = auto_r && (trig_sel_r == sac_pkg::TRIG_FREE);

  // Only a fresh rising edge of the selected source fires; a held level does not.
  assign trig_now      = trig_s2_r[trig_sel_r];
  assign trig_edge     = trig_now && !trig_prev_r;
  assign trig_fire     = auto_r && !freerun && eff_en && trig_edge && (state_r == sac_pkg::SAC_IDLE);
  assign presc_restart = trig_fire;

  sac_prescaler u_prescaler (
    .clock   (clock),
    .rst     (rst),
    .run     (eff_en),
    .restart (presc_restart),
    .div_sel (prescale_r),
    .tick    (conv_tick)
  );

  // Step schedule: sample, ten decisions, then completion on the last step.
  assign total       = first_r ? sac_pkg::STEPS_FIRST : sac_pkg::STEPS_NORMAL;
  assign last_step   = total - 5'h01;
  assign sample_step = total - sac_pkg::SAMPLE_LEAD;
  assign on_sample   = conv_tick && (state_r == sac_pkg::SAC_CONV) && (step_r == sample_step);
  assign on_decide   = conv_tick && (state_r == sac_pkg::SAC_CONV) && (step_r > sample_step) &&
                       (step_r < last_step);
  assign done        = conv_tick && (state_r == sac_pkg::SAC_CONV) && (step_r == last_step);

  // Keep the trial bit if the input exceeds the trial level, then try the next one.
  assign bit_hot  = 10'h001 << bit_r;
  assign sar_kept = dec_s2_r ? sar_r : (sar_r & ~bit_hot);
  assign sar_nxt  = sar_kept | (bit_hot >> 1);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      sac_pkg::SAC_IDLE: begin
        if (wr_start || trig_fire) begin
          state_nxt = sac_pkg::SAC_WAIT;
        end
      end
      sac_pkg::SAC_WAIT: begin
        if (conv_tick) begin
          state_nxt = sac_pkg::SAC_CONV;
        end
      end
      sac_pkg::SAC_CONV: begin
        if (done && !freerun) begin
          state_nxt = sac_pkg::SAC_IDLE;
        end
      end
      default: begin
        state_nxt = sac_pkg::SAC_IDLE;
      end
    endcase
    // A start written together with the enable bit must not be lost to the off state.
    if (!eff_en) begin
      state_nxt = (wr_start && !power_red_r) ? sac_pkg::SAC_WAIT : sac_pkg::SAC_IDLE;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r <= sac_pkg::SAC_IDLE;
      step_r  <= 5'h00;
    end else begin
      state_r <= state_nxt;
      if (state_r == sac_pkg::SAC_WAIT || done) begin
        step_r <= 5'h00;
      end else if (conv_tick) begin
        step_r <= step_r + 5'h01;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sar_r    <= sac_pkg::RESULT_RST;
      bit_r    <= sac_pkg::SAR_TOP_BIT;
      sample_r <= 1'b0;
    end else begin
      sample_r <= on_sample;
      if (on_sample) begin
        sar_r <= sac_pkg::SAR_MSB;
        bit_r <= sac_pkg::SAR_TOP_BIT;
      end else if (on_decide) begin
        sar_r <= sar_nxt;
        bit_r <= bit_r - 4'h1;
      end
    end
  end

  // A first conversion is due whenever the converter has been off.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      first_r <= 1'b1;
    end else if (!eff_en) begin
      first_r <= 1'b1;
    end else if (done) begin
      first_r <= 1'b0;
    end
  end

  // Result, lock and flag. Set wins over the software clear.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      data_r <= sac_pkg::RESULT_RST;
      lock_r <= 1'b0;
      flag_r <= 1'b0;
    end else begin
      if (done && !lock_r) begin
        data_r <= sar_r;
      end
      if (rd_lo) begin
        lock_r <= 1'b1;
      end else if (rd_hi) begin
        lock_r <= 1'b0;
      end
      if (done) begin
        flag_r <= 1'b1;
      end else if (wr_ctrl_a && pwdata[sac_pkg::CA_FLAG]) begin
        flag_r <= 1'b0;
      end
    end
  end

  // Selections are frozen during a conversion and reach the core only when enabled.
  assign update_sel = eff_en && ((state_r != sac_pkg::SAC_CONV) || done);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      applied_ch_r  <= 4'h0;
      applied_ref_r <= 2'h0;
    end else if (update_sel) begin
      applied_ch_r  <= chref_r[3:0];
      applied_ref_r <= chref_r[sac_pkg::CR_REF_HI:sac_pkg::CR_REF_LO];
    end
  end

  // Software registers.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      chref_r      <= sac_pkg::CHREF_RST;
      enable_r     <= sac_pkg::CTRL_A_RST[sac_pkg::CA_ENABLE];
      auto_r       <= sac_pkg::CTRL_A_RST[sac_pkg::CA_AUTO];
      ie_r         <= sac_pkg::CTRL_A_RST[sac_pkg::CA_IE];
      prescale_r   <= sac_pkg::CTRL_A_RST[2:0];
      cmp_mux_en_r <= sac_pkg::CTRL_B_RST[sac_pkg::CB_CMPMUX];
      trig_sel_r   <= sac_pkg::CTRL_B_RST[2:0];
      pin_dis_r    <= sac_pkg::PIN_DIS_RST;
      power_red_r  <= sac_pkg::POWER_RST;
    end else begin
      if (wr_chref) begin
        chref_r <= pwdata[7:0] & 8'hef;
      end
      if (wr_ctrl_a) begin
        enable_r   <= pwdata[sac_pkg::CA_ENABLE];
        auto_r     <= pwdata[sac_pkg::CA_AUTO];
        ie_r       <= pwdata[sac_pkg::CA_IE];
        prescale_r <= pwdata[2:0];
      end
      if (wr_ctrl_b) begin
        cmp_mux_en_r <= pwdata[sac_pkg::CB_CMPMUX];
        trig_sel_r   <= pwdata[2:0];
      end
      if (wr_pin_dis) begin
        pin_dis_r <= pwdata[1:0];
      end
      if (wr_power) begin
        power_red_r <= pwdata[sac_pkg::PW_REDUCE];
      end
    end
  end

  // Two-stage synchronisers for pins and the analog decision.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      trig_s1_r   <= 8'h00;
      trig_s2_r   <= 8'h00;
      trig_prev_r <= 1'b0;
      dec_s1_r    <= 1'b0;
      dec_s2_r    <= 1'b0;
      pin_s1_r    <= 2'h0;
      pin_s2_r    <= 2'h0;
      port_in_r   <= 2'h0;
    end else begin
      trig_s1_r   <= trigger_sources;
      trig_s2_r   <= trig_s1_r;
      trig_prev_r <= trig_now;
      dec_s1_r    <= core_decision;
      dec_s2_r    <= dec_s1_r;
      pin_s1_r    <= comparator_pin_raw;
      pin_s2_r    <= pin_s1_r;
      port_in_r   <= pin_s2_r & ~pin_dis_r;
    end
  end

  // Comparator negative input routing.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      neg_mux_r <= 1'b0;
      neg_ch_r  <= 3'h0;
    end else begin
      neg_mux_r <= cmp_mux_en_r && !enable_r;
      neg_ch_r  <= chref_r[2:0];
    end
  end

  // Read data, justified on the fly by the live left adjust bit.
  assign res_hi    = chref_r[sac_pkg::CR_LEFT] ? data_r[9:2] : {6'h00, data_r[9:8]};
  assign res_lo    = chref_r[sac_pkg::CR_LEFT] ? {data_r[1:0], 6'h00} : data_r[7:0];
  assign ctrl_a_rd = {enable_r, (state_r != sac_pkg::SAC_IDLE), auto_r, flag_r, ie_r, prescale_r};
  assign rd_byte   = (paddr == sac_pkg::ADDR_CHREF)   ? chref_r :
                     (paddr == sac_pkg::ADDR_CTRL_A)  ? ctrl_a_rd :
                     (paddr == sac_pkg::ADDR_CTRL_B)  ? {1'b0, cmp_mux_en_r, 3'h0, trig_sel_r} :
                     (paddr == sac_pkg::ADDR_RES_LO)  ? res_lo :
                     (paddr == sac_pkg::ADDR_RES_HI)  ? res_hi :
                     (paddr == sac_pkg::ADDR_PIN_DIS) ? {6'h00, pin_dis_r} :
                     (paddr == sac_pkg::ADDR_POWER)   ? {7'h00, power_red_r} : 8'h00;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prdata_r <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_r <= {24'h00_0000, rd_byte};
    end
  end

  assign prdata                  = prdata_r;
  assign core_enable             = eff_en;
  assign core_channel            = applied_ch_r;
  assign core_reference          = applied_ref_r;
  assign core_sample             = sample_r;
  assign dac_code                = sar_r;
  assign port_input_bits         = port_in_r;
  assign comparator_neg_from_mux = neg_mux_r;
  assign comparator_neg_channel  = neg_ch_r;
  assign conversion_irq          = flag_r && ie_r;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence s_start_req;
    wr_start && (state_r == sac_pkg::SAC_IDLE) && eff_en;
  endsequence

  sequence s_enter_conv;
    (state_r == sac_pkg::SAC_WAIT) && conv_tick ##1 (state_r == sac_pkg::SAC_CONV) && (step_r == 5'h00);
  endsequence

  start_request_a: assert property (s_start_req |=> (state_r == sac_pkg::SAC_WAIT) && ctrl_a_rd[6])
    else $error("start write did not begin a conversion");
  conv_entry_a: assert property ((state_r == sac_pkg::SAC_WAIT) && conv_tick && eff_en |-> s_enter_conv)
    else $error("conversion did not begin at step zero");
  busy_reads_a: assert property (
    rd_setup && (paddr == sac_pkg::ADDR_CTRL_A) && (state_r != sac_pkg::SAC_IDLE) |=> prdata[sac_pkg::CA_START])
    else $error("start bit low during a conversion");
  lock_hold_a: assert property (lock_r && !rd_hi |=> $stable(data_r))
    else $error("result changed while blocked");
  unlock_hi_a: assert property (rd_hi |=> !lock_r)
    else $error("high byte read did not unblock");
  flag_on_done_a: assert property (done |=> flag_r)
    else $error("completion flag not set");
  trig_ignored_a: assert property (
    trig_edge && (state_r == sac_pkg::SAC_CONV) |=> state_r != sac_pkg::SAC_WAIT)
    else $error("trigger edge accepted while busy");
  presc_hold_a: assert property (!eff_en |-> !conv_tick)
    else $error("prescaler ticked while disabled");
  single_done_a: assert property (done && !freerun && eff_en |=> state_r == sac_pkg::SAC_IDLE)
    else $error("single conversion did not end");
  free_run_a: assert property (
    done && freerun && eff_en |=> (state_r == sac_pkg::SAC_CONV) && (step_r == 5'h00))
    else $error("free running did not restart");
  pin_off_a: assert property (pin_dis_r[0] && $past(pin_dis_r[0]) |-> !port_input_bits[0])
    else $error("disabled pin input reads one");
  cmp_route_a: assert property (comparator_neg_from_mux |-> $past(cmp_mux_en_r) && !$past(enable_r))
    else $error("comparator routed from pins while enabled");

endmodule : sac_conversion_control

// *** sac_pkg.sv ***
// Purpose: Shared constants for the converter conversion control block.
// Assumes: APB register map with one aligned 32-bit word per register.
// Notes:   Offsets are byte addresses; data sits in the low byte.
package sac_pkg;

  localparam logic [7:0] ADDR_CHREF   = 8'h00;
  localparam logic [7:0] ADDR_CTRL_A  = 8'h04;
  localparam logic [7:0] ADDR_CTRL_B  = 8'h08;
  localparam logic [7:0] ADDR_RES_LO  = 8'h0c;
  localparam logic [7:0] ADDR_RES_HI  = 8'h10;
  localparam logic [7:0] ADDR_PIN_DIS = 8'h14;
  localparam logic [7:0] ADDR_POWER   = 8'h18;

  localparam int CR_REF_HI  = 7;
  localparam int CR_REF_LO  = 6;
  localparam int CR_LEFT    = 5;
  localparam int CA_ENABLE  = 7;
  localparam int CA_START   = 6;
  localparam int CA_AUTO    = 5;
  localparam int CA_FLAG    = 4;
  localparam int CA_IE      = 3;
  localparam int CB_CMPMUX  = 6;
  localparam int PD_NEG     = 1;
  localparam int PD_POS     = 0;
  localparam int PW_REDUCE  = 0;

  localparam logic [7:0] CHREF_RST   = 8'h00;
  localparam logic [7:0] CTRL_A_RST  = 8'h00;
  localparam logic [7:0] CTRL_B_RST  = 8'h00;
  localparam logic [1:0] PIN_DIS_RST = 2'h0;
  localparam logic       POWER_RST   = 1'b0;
  localparam logic [9:0] RESULT_RST  = 10'h000;

  localparam logic [4:0] STEPS_NORMAL = 5'h0d;
  localparam logic [4:0] STEPS_FIRST  = 5'h19;
  localparam logic [4:0] SAMPLE_LEAD  = 5'h0c;
  localparam logic [9:0] SAR_MSB      = 10'h200;
  localparam logic [3:0] SAR_TOP_BIT  = 4'h9;

  localparam logic [2:0] TRIG_FREE   = 3'h0;
  localparam logic [3:0] CH_BANDGAP  = 4'he;
  localparam logic [3:0] CH_GROUND   = 4'hf;

  typedef enum logic [1:0] {
    SAC_IDLE = 2'b00,
    SAC_WAIT = 2'b01,
    SAC_CONV = 2'b11
  } sac_state_e;

endpackage : sac_pkg

// *** sac_prescaler.sv ***
// Purpose: Converter clock prescaler producing one-cycle step ticks.
// Assumes: Division ratio is two shifted left by the select value.
// Notes:   Held at zero while not running; restart starts a full period.
`timescale 1ns/1ns
module sac_prescaler (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic       restart,
  input  wire logic [2:0] div_sel,
  output logic            tick
);

  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic [7:0] limit;

  assign limit   = 8'((9'h002 << div_sel) - 9'h001);
  assign tick    = run && !restart && (cnt_r == limit);
  assign cnt_nxt = (!run || restart || tick) ? 8'h00 : cnt_r + 8'h01;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule : sac_prescaler

// *** sac_core_model.sv ***
// Purpose: Behavioural analog core with sample-and-hold and comparator.
// Assumes: The level is held on the sample pulse from the applied channel.
// Notes:   Levels sit half a step above their code, so the search ends on it.
`timescale 1ns/1ns
module sac_core_model #(
  parameter logic [9:0] BANDGAP_CODE = 10'h1c2
) (
  input  wire logic            clock,
  input  wire logic            rst,
  input  wire logic            core_enable,
  input  wire logic [3:0]      core_channel,
  input  wire logic            core_sample,
  input  wire logic [9:0]      dac_code,
  input  wire logic [7:0][9:0] pin_level,
  output logic                 core_decision
);
  logic [9:0] held_r;
  logic       toggle_r;
  wire  [9:0] picked = (core_channel == 4'he) ? BANDGAP_CODE :
                       (core_channel == 4'hf) ? 10'h000 : pin_level[core_channel[2:0]];
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      held_r   <= 10'h000;
      toggle_r <= 1'b0;
    end else begin
      toggle_r <= ~toggle_r;
      if (core_sample) begin
        held_r <= picked;
      end
    end
  end
  // A core that is switched off gives no steady decision, so it toggles.
  assign core_decision = core_enable ? (held_r >= dac_code) : toggle_r;
endmodule : sac_core_model

// *** test_sac_conversion_control.sv ***
// Purpose: Self-checking bench for the conversion control block.
// Assumes: Prescale select 3, so one converter step is 16 clocks.
// Notes:   Pin levels are random from a fixed seed.
`timescale 1ns/1ns
module test_sac_conversion_control;
  localparam logic [9:0] BG = 10'h2a5;
  localparam logic [7:0] PS = 8'h03;
  localparam logic [3:0] CHS [6] = '{4'h0, 4'h7, 4'he, 4'hf, 4'h3, 4'h6};
  logic            clock = 1'b0;
  logic            rst = 1'b1;
  logic            psel = 1'b0;
  logic            penable = 1'b0;
  logic            pwrite = 1'b0;
  logic [7:0]      paddr = 8'h00;
  logic [31:0]     pwdata = 32'h0;
  logic [7:0]      trig = 8'h00;
  logic [1:0]      raw = 2'h0;
  logic [7:0][9:0] pins = '0;
  logic [31:0]     prdata, q;
  logic [9:0]      dac_code, lastv;
  logic [3:0]      core_channel;
  logic [2:0]      cch;
  logic [1:0]      core_ref, pib;
  logic            pready, pslverr, err, core_decision, core_enable, core_sample, cmx, irq, lastl;
  int              fails = 0, n_compared = 0, seed = 32'h4e71, ns = 0, cyc = 0, t0, t, i, k;

  sac_conversion_control uut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trigger_sources(trig), .core_decision(core_decision),
    .core_enable(core_enable), .core_channel(core_channel), .core_reference(core_ref),
    .core_sample(core_sample), .dac_code(dac_code), .comparator_pin_raw(raw),
    .port_input_bits(pib), .comparator_neg_from_mux(cmx), .comparator_neg_channel(cch),
    .conversion_irq(irq));
  sac_core_model #(.BANDGAP_CODE(BG)) core (.clock(clock), .rst(rst), .core_enable(core_enable),
    .core_channel(core_channel), .core_sample(core_sample), .dac_code(dac_code),
    .pin_level(pins), .core_decision(core_decision));

  initial forever #50 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;
  always @(posedge clock) if (core_sample === 1'b1) ns <= ns + 1;

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic rnd();
    for (int j = 0; j < 8; j++) pins[j] <= 10'($random(seed));
  endtask : rnd

  function automatic logic [9:0] expv(input logic [3:0] ch);
    if (ch == 4'he) return BG;
    if (ch == 4'hf) return 10'h000;
    return pins[ch[2:0]];
  endfunction : expv

  function automatic logic [15:0] just(input logic [9:0] v, input logic l);
    return l ? {v, 6'h00} : {6'h00, v};
  endfunction : just

  task automatic idle();
    do rd(sac_pkg::ADDR_CTRL_A); while (q[6] !== 1'b0);
    t = cyc - t0;
  endtask : idle

  task automatic res(input logic [9:0] v, input logic l);
    logic [7:0] lo;
    rd(sac_pkg::ADDR_RES_LO);
    lo = q[7:0];
    rd(sac_pkg::ADDR_RES_HI);
    chk("result", {q[7:0], lo}, just(v, l));
  endtask : res

  task automatic conv(input logic [3:0] ch, input logic l, input logic [7:0] ca, input logic [3:0] mid);
    wr(sac_pkg::ADDR_CHREF, {2'b01, l, 1'b0, ch});
    wr(sac_pkg::ADDR_CTRL_A, 8'hd0 | ca | PS);
    t0 = cyc;
    rd(sac_pkg::ADDR_CTRL_A);
    chk("busy", q[6], 1'b1);
    if (mid != ch) begin
      repeat (40) @(posedge clock);
      wr(sac_pkg::ADDR_CHREF, {2'b01, l, 1'b0, mid});
      chk("held channel", core_channel, ch);
    end
    idle();
    chk("flag", q[4], 1'b1);
    chk("dac code", dac_code, expv(ch));
    if (mid != ch) chk("new channel", core_channel, mid);
    res(expv(ch), l);
    lastv = expv(ch);
    lastl = l;
  endtask : conv

  initial begin
    rnd();
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    for (i = 0; i < 7; i++) begin
      rd(8'(4 * i));
      chk("reset value", q, 32'h0);
    end
    rd(8'h1c);
    chk("unmapped error", err, 1'b1);
    chk("unmapped data", q, 32'h0);
    $display("test registers done");
    wr(sac_pkg::ADDR_POWER, 32'h0);
    wr(sac_pkg::ADDR_CTRL_B, 32'h40);
    wr(sac_pkg::ADDR_CHREF, 32'h45);
    repeat (3) @(posedge clock);
    chk("mux route", {cmx, cch}, 4'hd);
    chk("not applied", {core_enable, core_ref, core_channel}, 7'h00);
    for (i = 0; i < 4; i++) begin
      raw <= 2'($random(seed));
      wr(sac_pkg::ADDR_PIN_DIS, i);
      repeat (4) @(posedge clock);
      chk("pin input", pib, raw & ~2'(i));
    end
    $display("test comparator done");
    conv(4'h5, 1'b0, 8'h00, 4'h5);
    chk("first time", t >= 384 && t <= 432, 1'b1);
    chk("mux off", {cmx, core_ref, core_channel}, 7'h15);
    chk("irq masked", irq, 1'b0);
    for (i = 0; i < 6; i++) begin
      rnd();
      conv(CHS[i], i[0], 8'h00, CHS[i]);
      chk("normal time", t >= 192 && t <= 240, 1'b1);
    end
    $display("test conversions done");
    rnd();
    rd(sac_pkg::ADDR_RES_LO);
    wr(sac_pkg::ADDR_CTRL_A, 8'h98 | PS);
    rd(sac_pkg::ADDR_CTRL_A);
    chk("flag cleared", {q[4], irq}, 2'b00);
    wr(sac_pkg::ADDR_CTRL_A, 8'hc8 | PS);
    idle();
    chk("lost flag", {q[4], irq}, 2'b11);
    res(lastv, lastl);
    conv(4'h2, 1'b0, 8'h00, 4'h2);
    conv(4'h1, 1'b1, 8'h00, 4'h6);
    $display("test lock and channel done");
    wr(sac_pkg::ADDR_CTRL_B, 32'h03);
    wr(sac_pkg::ADDR_CTRL_A, 8'ha0 | PS);
    k = ns;
    trig[3] <= 1'b1;
    repeat (50) @(posedge clock);
    rd(sac_pkg::ADDR_CTRL_A);
    chk("trigger busy", q[6], 1'b1);
    trig[3] <= 1'b0;
    repeat (4) @(posedge clock);
    trig[3] <= 1'b1;
    repeat (400) @(posedge clock);
    chk("one conversion", ns - k, 1);
    trig[3] <= 1'b0;
    conv(4'h4, 1'b0, 8'h20, 4'h4);
    wr(sac_pkg::ADDR_CTRL_B, 32'h00);
    k = ns;
    wr(sac_pkg::ADDR_CTRL_A, 8'he0 | PS);
    repeat (700) @(posedge clock);
    rd(sac_pkg::ADDR_CTRL_A);
    chk("free running", {q[6], q[4], ns - k >= 3}, 3'b111);
    wr(sac_pkg::ADDR_CTRL_A, 8'h80 | PS);
    idle();
    wr(sac_pkg::ADDR_POWER, 32'h1);
    repeat (2) @(posedge clock);
    chk("power off", core_enable, 1'b0);
    $display("test triggers done");
    conclude();
  end

  initial begin
    repeat (40000) @(posedge clock);
    fails++;
    $display("test watchdog expired");
    conclude();
  end
endmodule : test_sac_conversion_control
